// [logic/shift_reg4_pkg.sv]
// package for the four-stage bidirectional shift register
// assumes a single clock domain and a synchronous active-low system reset
package shift_reg4_pkg;

  // ----------------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------------
  localparam int unsigned STAGES      = 4;
  localparam logic [3:0]  STAGE_RESET = 4'h0;
  localparam int unsigned POS_FIRST   = 0;
  localparam int unsigned POS_LAST    = 3;
  localparam int unsigned SYNC_DEPTH  = 3;

  // mode encoding: {mode_sel_high, mode_sel_low}
  localparam logic [1:0] MODE_HOLD  = 2'h0;
  localparam logic [1:0] MODE_RIGHT = 2'h1;
  localparam logic [1:0] MODE_LEFT  = 2'h2;
  localparam logic [1:0] MODE_LOAD  = 2'h3;

endpackage : shift_reg4_pkg

// [logic/pin_sync3.sv]
// three-flop synchroniser with agreement filter for a bundle of pins
// assumes pins are asynchronous to core_clk; rst_n is synchronous
module pin_sync3
  import shift_reg4_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  // ----------------------------------------------------------------------
  // sync chain
  // ----------------------------------------------------------------------
  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] s1_d, s2_d, s3_d, lvl_d;

  // a change is taken only when stages two and three agree
  always_comb begin
    s1_d  = pin;
    s2_d  = s1_q;
    s3_d  = s2_q;
    lvl_d = lvl_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // registers only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;

endmodule : pin_sync3

// [logic/bidir_universal_shift_reg4.sv]
// four-stage bidirectional universal shift register with output buffer
// assumes the ten device pin inputs come from outside the core_clk domain, while OUT_READY is in it; the
// shift edge is the rising edge of the synchronised device clock pin
module bidir_universal_shift_reg4
  import shift_reg4_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RST_N,
  input  wire logic       SHIFT_CLK,
  input  wire logic       OVERRIDING_CLEAR_N,
  input  wire logic       MODE_SEL_LOW,
  input  wire logic       MODE_SEL_HIGH,
  input  wire logic       RIGHT_SHIFT_SERIAL_IN,
  input  wire logic       LEFT_SHIFT_SERIAL_IN,
  input  wire logic [3:0] PARALLEL_IN,
  output logic            STAGE_OUT_FIRST,
  output logic            STAGE_OUT_SECOND,
  output logic            STAGE_OUT_THIRD,
  output logic            STAGE_OUT_LAST,
  output logic      [3:0] OUT_DATA,
  output logic            OUT_VALID,
  input  wire logic       OUT_READY
);

  // ----------------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------------
  logic [9:0] pins;
  logic [9:0] lvl;
  assign pins = {SHIFT_CLK, OVERRIDING_CLEAR_N, MODE_SEL_HIGH, MODE_SEL_LOW,
                 RIGHT_SHIFT_SERIAL_IN, LEFT_SHIFT_SERIAL_IN, PARALLEL_IN};

  pin_sync3 #(
    .W (10)
  ) u_sync (
    .core_clk (CORE_CLK),
    .rst_n    (RST_N),
    .pin      (pins),
    .level    (lvl)
  );

  logic       clk_lvl, clear_n, sr_in, sl_in;
  logic [1:0] mode;
  logic [3:0] par_in;
  assign clk_lvl = lvl[9];
  assign clear_n = lvl[8];
  assign mode    = lvl[7:6];
  assign sr_in   = lvl[5];
  assign sl_in   = lvl[4];
  assign par_in  = lvl[3:0];

  // ----------------------------------------------------------------------
  // edge detect on the filtered device clock
  // ----------------------------------------------------------------------
  logic clk_prev_q, clk_prev_d;
  logic rise;

  // previous level rests low through reset (RST_N) so the first edge after
  // release is seen cleanly; through clear it follows the filtered clock
  always_comb begin
    clk_prev_d = clk_lvl;
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= clk_prev_d;
    end
  end

  assign rise = clk_lvl & ~clk_prev_q;

  // ----------------------------------------------------------------------
  // stage register
  // ----------------------------------------------------------------------
  // stage index 0 is the first stage, index 3 the last
  logic [3:0] stage_q, stage_d;
  logic       changed;

  function automatic logic [3:0] next_stage(
    input logic [1:0] m,
    input logic [3:0] cur,
    input logic [3:0] par,
    input logic       sr,
    input logic       sl
  );
    logic [3:0] r;
    r = cur;
    case (m)
      MODE_LOAD:  r = par;
      MODE_RIGHT: r = {cur[2:0], sr};
      MODE_LEFT:  r = {sl, cur[3:1]};
      MODE_HOLD:  r = cur;
      default:    r = cur;
    endcase
    return r;
  endfunction : next_stage

  // clear wins over any simultaneous edge
  always_comb begin
    stage_d = stage_q;
    if (!clear_n) begin
      stage_d = STAGE_RESET;
    end else if (rise) begin
      stage_d = next_stage(mode, stage_q, par_in, sr_in, sl_in);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      stage_q <= STAGE_RESET;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign changed = (stage_d != stage_q);

  // ----------------------------------------------------------------------
  // two-entry output buffer
  // ----------------------------------------------------------------------
  // each new stage value is pushed; when the reader stalls and both
  // entries are full the newest change is dropped, a limitation of a
  // register that cannot itself stall its own pin clock; the oldest
  // entry is what the reader sees on OUT_DATA
  typedef enum logic [2:0] {
    BUF_EMPTY = 3'b001,
    BUF_ONE   = 3'b010,
    BUF_TWO   = 3'b100
  } buf_state_t;

  buf_state_t bst_q, bst_d;
  logic [3:0] e0_q, e0_d, e1_q, e1_d;
  logic       push, pop;

  assign pop  = OUT_READY & (bst_q != BUF_EMPTY);
  assign push = changed & ((bst_q != BUF_TWO) | pop);

  always_comb begin
    bst_d = bst_q;
    e0_d  = e0_q;
    e1_d  = e1_q;
    case (bst_q)
      BUF_EMPTY: begin
        if (push) begin
          e0_d  = stage_d;
          bst_d = BUF_ONE;
        end
      end
      BUF_ONE: begin
        if (push && pop) begin
          e0_d = stage_d;
        end else if (push) begin
          e1_d  = stage_d;
          bst_d = BUF_TWO;
        end else if (pop) begin
          bst_d = BUF_EMPTY;
        end
      end
      BUF_TWO: begin
        if (pop) begin
          e0_d = e1_q;
          if (push) begin
            e1_d = stage_d;
          end else begin
            bst_d = BUF_ONE;
          end
        end
      end
      default: begin
        bst_d = BUF_EMPTY;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      bst_q <= BUF_EMPTY;
      e0_q  <= STAGE_RESET;
      e1_q  <= STAGE_RESET;
    end else begin
      bst_q <= bst_d;
      e0_q  <= e0_d;
      e1_q  <= e1_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // parallel outputs always show the live stages
  assign STAGE_OUT_FIRST  = stage_q[POS_FIRST];
  assign STAGE_OUT_SECOND = stage_q[1];
  assign STAGE_OUT_THIRD  = stage_q[2];
  assign STAGE_OUT_LAST   = stage_q[POS_LAST];
  assign OUT_DATA         = e0_q; // head entry, straight from a flop
  assign OUT_VALID        = (bst_q != BUF_EMPTY);

endmodule : bidir_universal_shift_reg4

// [dv/shift_reg4_properties.sv]
// port-level checker for the four-stage shift register
// assumes every pin is held at least 8 core cycles between changes
module shift_reg4_checker (
  input wire logic       CORE_CLK,
  input wire logic       RST_N,
  input wire logic       SHIFT_CLK,
  input wire logic       OVERRIDING_CLEAR_N,
  input wire logic       MODE_SEL_LOW,
  input wire logic       MODE_SEL_HIGH,
  input wire logic       RIGHT_SHIFT_SERIAL_IN,
  input wire logic       LEFT_SHIFT_SERIAL_IN,
  input wire logic [3:0] PARALLEL_IN,
  input wire logic       STAGE_OUT_FIRST,
  input wire logic       STAGE_OUT_SECOND,
  input wire logic       STAGE_OUT_THIRD,
  input wire logic       STAGE_OUT_LAST,
  input wire logic [3:0] OUT_DATA,
  input wire logic       OUT_VALID,
  input wire logic       OUT_READY
);
  logic [3:0] s;
  assign s = {STAGE_OUT_LAST, STAGE_OUT_THIRD, STAGE_OUT_SECOND,
              STAGE_OUT_FIRST};
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // a pin rise in one mode; clear must stay off while the sync catches up
  sequence edge_in(logic [1:0] m);
    $rose(SHIFT_CLK) && {MODE_SEL_HIGH, MODE_SEL_LOW} == m
      ##1 OVERRIDING_CLEAR_N [*8];
  endsequence
  load_data_a: assert property (edge_in(2'h3) |->
    s == $past(PARALLEL_IN, 8)) else $error("load result wrong");
  shift_right_a: assert property (edge_in(2'h1) |->
    s == {$past(s[2:0], 8), $past(RIGHT_SHIFT_SERIAL_IN, 8)})
    else $error("right shift wrong");
  shift_left_a: assert property (edge_in(2'h2) |->
    s == {$past(LEFT_SHIFT_SERIAL_IN, 8), $past(s[3:1], 8)})
    else $error("left shift wrong");
  hold_mode_a: assert property ((OVERRIDING_CLEAR_N && !MODE_SEL_LOW &&
    !MODE_SEL_HIGH) [*8] |-> $stable(s)) else $error("hold moved");
  clock_still_a: assert property (($stable(SHIFT_CLK) &&
    $stable(OVERRIDING_CLEAR_N)) [*8] |-> $stable(s))
    else $error("stages moved without edge");
  clear_low_a: assert property (!OVERRIDING_CLEAR_N [*8] |->
    s == 4'h0) else $error("clear did not zero");
  // the push lands on the same edge as the stage change, so a reader
  // that pops at once may already have emptied the buffer one cycle on
  push_valid_a: assert property (!$stable(s) |-> OUT_VALID)
    else $error("change not buffered");
  valid_hold_a: assert property (OUT_VALID && !OUT_READY |=>
    OUT_VALID) else $error("buffer lost word");
  data_hold_a: assert property (OUT_VALID && !OUT_READY |=>
    $stable(OUT_DATA)) else $error("buffered word moved");
  first_word_a: assert property (!$stable(s) && !$past(OUT_VALID) |->
    OUT_DATA == s) else $error("first word not buffered");
endmodule : shift_reg4_checker

bind bidir_universal_shift_reg4 shift_reg4_checker shift_reg4_checker_inst (.*);

// [dv/out_sink.sv]
// sink beyond the output buffer, pops on a fixed pattern
// assumes stall is driven by the bench at the rising edge
module out_sink (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic stall,
  output logic      ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  // ready drops one cycle in four so pops never run back to back for more than three cycles
  always_ff @(posedge clk) begin
    cnt_q <= rst_n ? cnt_q + 2'h1 : 2'h0;
    ready <= rst_n && !stall && cnt_q != 2'h0;
  end
endmodule : out_sink

// [dv/bidir_universal_shift_reg4_bench.sv]
// random and corner-case bench for the four-stage shift register
// assumes the checker is bound in; each pin is held 8 core cycles
module bidir_universal_shift_reg4_bench
  import shift_reg4_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------------
  // stimulus and expectation
  // ------------------------------------------------------------------
  logic       clk = 0, rst_n = 0, sclk = 0, clr_n = 0, lo = 0, hi = 0;
  logic       sr = 0, sl = 0, stall = 0, rdy, valid;
  logic [3:0] par = 4'h0, exp_q = 4'h0;
  wire  [3:0] q, odata;
  logic [31:0] r;
  int         bad_count = 0, total_checks = 0, k;
  integer     seed = 32'haff38d12;
  initial forever #2 clk = ~clk;
  bidir_universal_shift_reg4 bidir_universal_shift_reg4_inst (
    .CORE_CLK(clk), .RST_N(rst_n), .SHIFT_CLK(sclk),
    .OVERRIDING_CLEAR_N(clr_n), .MODE_SEL_LOW(lo), .MODE_SEL_HIGH(hi),
    .RIGHT_SHIFT_SERIAL_IN(sr), .LEFT_SHIFT_SERIAL_IN(sl),
    .PARALLEL_IN(par), .STAGE_OUT_FIRST(q[0]), .STAGE_OUT_SECOND(q[1]),
    .STAGE_OUT_THIRD(q[2]), .STAGE_OUT_LAST(q[3]), .OUT_VALID(valid),
    .OUT_DATA(odata), .OUT_READY(rdy));
  out_sink out_sink_inst (.clk(clk), .rst_n(rst_n), .stall(stall),
    .ready(rdy));
  // clear wins over the edge, so a cleared step always expects zero
  function automatic logic [3:0] next_q(logic c, logic [1:0] m,
    logic [3:0] cur, logic [3:0] p, logic rin, logic lin);
    if (!c) return 4'h0;
    case (m)
      MODE_LOAD:  return p;
      MODE_RIGHT: return {cur[2:0], rin};
      MODE_LEFT:  return {lin, cur[3:1]};
      default:    return cur;
    endcase
  endfunction : next_q
  task automatic check(string what, logic [3:0] e, logic [3:0] got);
    total_checks++;
    if (e !== got) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask : check
  // one full pin cycle: set inputs, rise, fall, each held 8 cycles
  task automatic step(logic c, logic [1:0] m, logic [3:0] p, logic rin,
    logic lin);
    {clr_n, hi, lo, par, sr, sl} <= {c, m, p, rin, lin};
    repeat (8) @(posedge clk);
    sclk <= 1'b1;
    repeat (8) @(posedge clk);
    sclk <= 1'b0;
    repeat (8) @(posedge clk);
    exp_q = next_q(c, m, exp_q, p, rin, lin);
    check("stages", exp_q, q);
  endtask : step
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    step(1'b0, MODE_LOAD, 4'hf, 1'b1, 1'b1);
    step(1'b1, MODE_LOAD, 4'ha, 1'b1, 1'b1);
    for (int m = 0; m < 4; m++) begin
      step(1'b1, m[1:0], 4'h5, 1'b1, 1'b0);
    end
    $display("corner test done");
    for (int i = 0; i < 60; i++) begin
      r = $random(seed);
      stall <= i inside {[10:30]};
      step(r[2:0] != 3'h0, r[4:3], r[8:5], r[9], r[10]);
      if (i == 30) check("full valid", 4'h1, {3'h0, valid});
    end
    for (k = 0; k < 64 && valid !== 1'b0; k++) @(posedge clk);
    check("drained", 4'h0, {3'h0, valid});
    // once drained, the head entry is the last change, i.e. the stages
    check("last word", exp_q, odata);
    $display("random test done");
    finish_test();
  end
endmodule : bidir_universal_shift_reg4_bench
